// ---- hdl/lics_sequencer.sv ----
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - in CV, finish when current below termination or elapsed timer expires
// - after completion restart charging when battery below recharge threshold and qualified
// - timer runs slower by a set factor while thermal regulation is active
// - die over-temperature suspends charging; resumes automatically when it clears
// - supply below lockout forces power-down: charger off, outputs off
// - three timers: precondition 1.0 h, fast 1.5 h, elapsed 3.0 h, scaled
// - precondition timer runs from qualification, cleared on entering fast charge
// - fast and elapsed timers start when leaving preconditioning
// - fast timer cleared on entering CV; elapsed timer keeps running
// - two-output pattern: charge on/flash when charging/done, fault on/flash
// - single-output pattern: on while charging, flash on fault or bad temperature
// - outputs are open-drain: enable high sinks, low is high impedance
// - flash rate from the same divider as the safety timers, but not slowed by thermal regulation
// - fault latched until supply loss or enable low then high
// - bad cell temperature blocks or suspends the cycle without ending it
// - qualify on supply, enable, temperature; supply dip counts in the same clock
// - precondition or fast timer expiry flags a fault and ends the cycle
// - enable low disables and ends the cycle; high starts one
module lics_sequencer
  import lics_pkg::*;
#(
  parameter int HALF_FLASH = HALF_FLASH_CYC,
  parameter int PRECONDITION_TIMEOUT = PRECON_TICKS,
  parameter int T_FAST = FAST_TICKS,
  parameter int T_TERM = TERM_TICKS
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire lics_sense_t SENSE,
  input wire logic EN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic CHARGE_EN,
  output logic PRECON_MODE,
  output logic CHARGE_INDICATOR_O,
  output logic CHARGE_INDICATOR_OE,
  output logic FAULT_INDICATOR_O,
  output logic FAULT_INDICATOR_OE
);

  lics_state_t state_q, state_d;
  logic [31:0] ctrl_q;
  logic [DIV_W-1:0] div_q;
  logic [CTRL_SLOW_W-1:0] slow_q;
  logic tick_q, flash_q, en_prev_q, sup_lo_q;
  logic [TICK_W-1:0] pre_t_q, fast_t_q, term_t_q;
  logic qual, suspend, en_rise, go_fast, go_cv, go_done, go_fault;
  logic chg_on, flt_on;

  // qualification; a supply dip counts at once, with no one-clock filter
  assign qual = SENSE.supply_ok && EN && ctrl_q[CTRL_ENABLE_BIT];
  assign suspend = !SENSE.temp_valid || SENSE.die_hot;
  assign en_rise = EN && !en_prev_q;

  // supply-low registered, one clock behind the input
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      sup_lo_q <= 1'b0;
      en_prev_q <= 1'b0;
    end else begin
      sup_lo_q <= !SENSE.supply_ok;
      en_prev_q <= EN;
    end
  end

  // register slave, answers one cycle after the strobe
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      ctrl_q <= CTRL_RESET;
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
      if (WB_CYC_I && WB_STB_I && !WB_ACK_O) begin
        if (WB_WE_I && WB_ADR_I == ADDR_CTRL) begin
          for (int i = 0; i < 4; i++) begin
            if (WB_SEL_I[i]) begin
              ctrl_q[i*8 +: 8] <= WB_DAT_I[i*8 +: 8];
            end
          end
        end
        unique case (WB_ADR_I)
          ADDR_CTRL: WB_DAT_O <= ctrl_q;
          ADDR_STATUS: WB_DAT_O <= {16'h0000, SENSE, 5'h00, state_q};
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // scaled timebase: half-flash tick, slowed under thermal regulation
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      div_q <= '0;
      slow_q <= '0;
      tick_q <= 1'b0;
      flash_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (div_q == DIV_W'(HALF_FLASH - 1)) begin
        div_q <= '0;
        flash_q <= !flash_q;
        if (!SENSE.thermal_reg || slow_q == ctrl_q[CTRL_SLOW_LSB +: CTRL_SLOW_W]) begin
          slow_q <= '0;
          tick_q <= 1'b1;
        end else begin
          slow_q <= slow_q + 1'b1;
        end
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  // phase exits; each is qualified by the phase it leaves
  assign go_fast = state_q == ST_PRECON && SENSE.above_precon;
  assign go_cv = state_q == ST_FAST && SENSE.at_regulation;
  // completion on low current or a full elapsed timer
  assign go_done = state_q == ST_CV && (SENSE.below_term ||
                   term_t_q == TICK_W'(T_TERM));
  // expiry compares equal; a counter never passes its limit in its phase
  assign go_fault = (state_q == ST_PRECON && pre_t_q == TICK_W'(PRECONDITION_TIMEOUT)) ||
                    (state_q == ST_FAST && fast_t_q == TICK_W'(T_FAST));

  // charge cycle state selection
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_QUAL: begin
        // a bad cell temperature keeps the cycle from starting
        if (qual && !suspend) begin
          state_d = ST_PRECON;
        end
      end
      ST_PRECON: begin
        // expiry wins over a crossing seen in the same cycle
        if (go_fault) begin
          state_d = ST_FAULT;
        end else if (go_fast) begin
          state_d = ST_FAST;
        end
      end
      ST_FAST: begin
        if (go_fault) begin
          state_d = ST_FAULT;
        end else if (go_cv) begin
          state_d = ST_CV;
        end
      end
      ST_CV: begin
        if (go_done) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        // automatic recharge only while every qualification still holds
        if (SENSE.below_recharge && qual && !suspend) begin
          state_d = ST_PRECON;
        end
      end
      ST_FAULT: begin
        // only the override below leaves a fault
        state_d = ST_FAULT;
      end
      default: begin
        state_d = ST_QUAL;
      end
    endcase
    // enable low or supply loss ends everything, clearing faults
    if (!qual || sup_lo_q) begin
      state_d = ST_QUAL;
    end
  end

  // state register
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      state_q <= ST_QUAL;
    end else begin
      state_q <= state_d;
    end
  end

  // precondition timer; held while suspended so a pause never trips it
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      pre_t_q <= '0;
    end else if (state_d != ST_PRECON || state_q != ST_PRECON) begin
      pre_t_q <= '0;
    end else if (tick_q && !suspend) begin
      pre_t_q <= pre_t_q + 1'b1;
    end
  end

  // fast-charge timer: starts on leaving precondition, cleared in cv
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      fast_t_q <= '0;
    end else if (state_d != ST_FAST) begin
      fast_t_q <= '0;
    end else if (tick_q && !suspend) begin
      fast_t_q <= fast_t_q + 1'b1;
    end
  end

  // elapsed timer: runs through fast charge and cv, saturates when full
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      term_t_q <= '0;
    end else if (state_d != ST_FAST && state_d != ST_CV) begin
      term_t_q <= '0;
    end else if (tick_q && !suspend && term_t_q != TICK_W'(T_TERM)) begin
      term_t_q <= term_t_q + 1'b1;
    end
  end

  // status patterns per variant; they follow the next state so the
  // lamps change on the same edge as the charge enable
  always_comb begin
    chg_on = 1'b0;
    flt_on = 1'b0;
    if (ctrl_q[CTRL_SINGLE_BIT]) begin
      // single output: fault and bad temperature share the flash
      if (state_d == ST_FAULT || (qual && !SENSE.temp_valid)) begin
        chg_on = flash_q;
      end else begin
        chg_on = state_d inside {ST_PRECON, ST_FAST, ST_CV};
      end
    end else begin
      // two outputs: fault shown steady, bad temperature flashes
      if (state_d == ST_FAULT) begin
        flt_on = 1'b1;
      end else if (qual && !SENSE.temp_valid) begin
        flt_on = flash_q;
      end else if (state_d == ST_DONE) begin
        chg_on = flash_q;
      end else begin
        chg_on = state_d inside {ST_PRECON, ST_FAST, ST_CV};
      end
    end
    // dark in power-down and while disabled
    if (!qual || sup_lo_q) begin
      chg_on = 1'b0;
      flt_on = 1'b0;
    end
  end

  // open-drain lamp drive: the data side only ever pulls low
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      CHARGE_INDICATOR_O <= 1'b0;
      CHARGE_INDICATOR_OE <= 1'b0;
      FAULT_INDICATOR_O <= 1'b0;
      FAULT_INDICATOR_OE <= 1'b0;
    end else begin
      CHARGE_INDICATOR_O <= 1'b0;
      FAULT_INDICATOR_O <= 1'b0;
      CHARGE_INDICATOR_OE <= chg_on;
      FAULT_INDICATOR_OE <= flt_on;
    end
  end

  // pass device and trickle select; a suspend only drops the pass device
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      CHARGE_EN <= 1'b0;
      PRECON_MODE <= 1'b0;
    end else begin
      CHARGE_EN <= state_d inside {ST_PRECON, ST_FAST, ST_CV} && !suspend;
      PRECON_MODE <= state_d == ST_PRECON;
    end
  end

  logic unused_ok;
  assign unused_ok = en_rise;

endmodule

`default_nettype wire

// ---- include/lics_pkg.sv ----
package lics_pkg;

  // charge cycle states
  typedef enum logic [2:0] {
    ST_QUAL   = 3'h0,
    ST_PRECON = 3'h1,
    ST_FAST   = 3'h2,
    ST_CV     = 3'h3,
    ST_DONE   = 3'h4,
    ST_FAULT  = 3'h5
  } lics_state_t;

  // analog comparator results grouped
  typedef struct packed {
    logic supply_ok;
    logic above_precon;
    logic at_regulation;
    logic below_term;
    logic below_recharge;
    logic temp_valid;
    logic thermal_reg;
    logic die_hot;
  } lics_sense_t;

  // bits of the wishbone control/status word
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SINGLE_BIT = 1;
  localparam int CTRL_SLOW_LSB = 8;
  localparam int CTRL_SLOW_W = 4;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0201;

  // timer figures at 0.1 uF timing capacitance
  localparam int CLK_HZ = 25000000;
  localparam int FLASH_HZ = 1;
  localparam int PRECON_TENTHS_HR = 10;
  localparam int FAST_TENTHS_HR = 15;
  localparam int TERM_TENTHS_HR = 30;
  localparam int SEC_PER_TENTH_HR = 360;
  // one tick of the scaled timebase equals half a flash period
  localparam int HALF_FLASH_CYC = CLK_HZ / (2 * FLASH_HZ);
  localparam int PRECON_TICKS = PRECON_TENTHS_HR * SEC_PER_TENTH_HR * 2 * FLASH_HZ;
  localparam int FAST_TICKS = FAST_TENTHS_HR * SEC_PER_TENTH_HR * 2 * FLASH_HZ;
  localparam int TERM_TICKS = TERM_TENTHS_HR * SEC_PER_TENTH_HR * 2 * FLASH_HZ;
  localparam int TICK_W = 16;
  localparam int DIV_W = 25;

endpackage

// ---- bench/lics_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module lics_props
  import lics_pkg::*;
#(
  parameter int HALF_FLASH = 4,
  parameter int PRECONDITION_TIMEOUT = 6
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire lics_sense_t SENSE,
  input wire logic EN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic CHARGE_EN,
  input wire logic PRECON_MODE,
  input wire logic CHARGE_INDICATOR_O,
  input wire logic CHARGE_INDICATOR_OE,
  input wire logic FAULT_INDICATOR_O,
  input wire logic FAULT_INDICATOR_OE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  localparam int LIM = (PRECONDITION_TIMEOUT + 1) * HALF_FLASH + 2;
  logic [15:0] run_q;
  // trickle run length; restarts under slowdown, which stretches the timer
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || !PRECON_MODE || !CHARGE_EN || SENSE.thermal_reg) run_q <= 16'h0000;
    else run_q <= run_q + 16'h0001;
  end
  sequence req_s;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  a_ack_once:
    assert property (req_s |=> WB_ACK_O) else $error("request not acked");
  a_ack_drop:
    assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
  a_supply_off:
    assert property (!SENSE.supply_ok |=> !CHARGE_EN && !CHARGE_INDICATOR_OE
      && !FAULT_INDICATOR_OE) else $error("active without supply");
  a_enable_off:
    assert property (!EN |=> !CHARGE_EN && !CHARGE_INDICATOR_OE) else $error("runs disabled");
  a_hot_stop:
    assert property (SENSE.die_hot |=> !CHARGE_EN) else $error("charging while hot");
  a_temp_stop:
    assert property (!SENSE.temp_valid |=> !CHARGE_EN) else $error("charging bad temp");
  a_od_low:
    assert property (!CHARGE_INDICATOR_O && !FAULT_INDICATOR_O) else $error("pin driven high");
  a_charge_led:
    assert property (CHARGE_EN |-> CHARGE_INDICATOR_OE && !FAULT_INDICATOR_OE)
      else $error("charge led wrong");
  a_precon_bound:
    assert property (run_q <= LIM) else $error("trickle overran");
  a_start_qual:
    assert property ($rose(CHARGE_EN) |-> $past(EN) && $past(SENSE.supply_ok)
      && $past(SENSE.temp_valid)) else $error("start unqualified");
endmodule
bind lics_sequencer lics_props #(.HALF_FLASH(HALF_FLASH), .PRECONDITION_TIMEOUT(PRECONDITION_TIMEOUT)) lics_props_i (
  .CLK_SYS, .RSTN, .SENSE, .EN, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .CHARGE_EN, .PRECON_MODE,
  .CHARGE_INDICATOR_O, .CHARGE_INDICATOR_OE, .FAULT_INDICATOR_O, .FAULT_INDICATOR_OE);
`default_nettype wire

// ---- bench/lics_cell.sv ----
`timescale 1ns/1ps
`default_nettype none
module lics_cell
  import lics_pkg::*;
(
  input wire logic clk,
  input wire logic charge_en,
  input wire logic precon_mode,
  input wire logic stuck,
  input wire logic load,
  input wire logic [7:0] load_v,
  input wire logic [3:0] env,
  input wire logic chg_oe,
  input wire logic flt_oe,
  output lics_sense_t sense,
  output logic chg_pin,
  output logic flt_pin
);
  logic [7:0] v_q = 8'h00;
  // trickle rises slower than fast charge; a dead cell never rises
  always_ff @(posedge clk) begin
    if (load) v_q <= load_v;
    else if (charge_en && !stuck && v_q < 8'h40) v_q <= v_q + (precon_mode ? 8'h01 : 8'h02);
  end
  // current tapers to the end level at full charge
  assign sense = {env[3], v_q >= 8'h10, v_q >= 8'h30, v_q == 8'h40, v_q < 8'h20, env[2:0]};
  // pull-ups: a released line reads high
  assign chg_pin = chg_oe ? 1'b0 : 1'b1;
  assign flt_pin = flt_oe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
  import lics_pkg::*;
;
  logic clk = 0, rstn = 0, en = 0, cyc = 0, stb = 0, we = 0, ack, chg_en, pre, co, coe, fo, foe;
  logic stuck = 0, ld = 0, chg_pin, flt_pin;
  logic [7:0] adr = 8'h00, lv = 8'h00;
  logic [31:0] wd = 32'h0, rd, rv;
  logic [3:0] env = 4'hC;
  lics_sense_t sense;
  int errors = 0, cmp_count = 0;
  localparam int HF = 4;
  // free-running system clock
  initial forever #20 clk = ~clk;
  lics_sequencer #(.HALF_FLASH(HF), .PRECONDITION_TIMEOUT(6), .T_FAST(9), .T_TERM(18)) lics_sequencer_i (
    .CLK_SYS(clk), .RSTN(rstn), .SENSE(sense), .EN(en), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wd), .WB_SEL_I(4'hF), .WB_DAT_O(rd), .WB_ACK_O(ack),
    .CHARGE_EN(chg_en), .PRECON_MODE(pre), .CHARGE_INDICATOR_O(co), .CHARGE_INDICATOR_OE(coe),
    .FAULT_INDICATOR_O(fo), .FAULT_INDICATOR_OE(foe));
  lics_cell lics_cell_i (.clk(clk), .charge_en(chg_en), .precon_mode(pre), .stuck(stuck),
    .load(ld), .load_v(lv), .env(env), .chg_oe(coe), .flt_oe(foe), .sense(sense),
    .chg_pin(chg_pin), .flt_pin(flt_pin));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one classic cycle; data taken at the ack edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    rv = rd;
    {cyc, stb} <= 2'b00;
  endtask
  task wait_st(input logic [2:0] s);
    int i;
    i = 0;
    do begin
      wb(0, ADDR_STATUS, 0);
      i++;
    end while (rv[2:0] !== s && i < 100);
    chk("state", s, rv[2:0]);
  endtask
  task flash(input string n, input logic sel);
    logic a;
    a = sel ? flt_pin : chg_pin;
    idle(HF);
    chk(n, !a, sel ? flt_pin : chg_pin);
  endtask
  task t_regs;
    wb(0, ADDR_CTRL, 0);
    chk("ctrl", CTRL_RESET, rv);
    wb(1, ADDR_STATUS, 32'hFFFF_FFFF);
    wb(1, 8'h08, 32'h0);
    wb(0, ADDR_STATUS, 0);
    chk("status", {16'h0000, sense, 8'h00}, rv);
    wb(0, 8'h08, 0);
    chk("hole", 0, rv);
    wb(0, ADDR_CTRL, 0);
    chk("ctrl", CTRL_RESET, rv);
    $display("end regs");
  endtask
  task t_cycle;
    en <= 1;
    wait_st(ST_PRECON);
    chk("trickle", 1, pre);
    wait_st(ST_FAST);
    wait_st(ST_CV);
    wait_st(ST_DONE);
    chk("off", 0, chg_en);
    flash("done led", 0);
    {ld, lv} <= {1'b1, 8'h18};
    idle(1);
    ld <= 0;
    idle(3);
    chk("recharge", 1, chg_en);
    $display("end cycle");
  endtask
  task t_fault;
    en <= 0;
    {stuck, ld, lv} <= {2'b11, 8'h00};
    idle(2);
    ld <= 0;
    en <= 1;
    wait_st(ST_FAULT);
    chk("stop", 0, chg_en);
    chk("leds", 2'b10, {chg_pin, flt_pin});
    stuck <= 0;
    idle(HF);
    chk("steady", 0, flt_pin);
    wait_st(ST_FAULT);
    wb(1, ADDR_CTRL, 32'h0000_0203);
    flash("single", 0);
    wb(1, ADDR_CTRL, CTRL_RESET);
    en <= 0;
    idle(2);
    en <= 1;
    wait_st(ST_PRECON);
    $display("end fault");
  endtask
  task t_susp;
    env <= 4'h8;
    idle(3);
    chk("cold", 0, chg_en);
    flash("temp led", 1);
    wb(0, ADDR_STATUS, 0);
    chk("kept", 0, rv[2:0] == ST_QUAL);
    env <= 4'hD;
    idle(3);
    chk("hot", 0, chg_en);
    env <= 4'hC;
    idle(3);
    chk("resume", 1, chg_en);
    env <= 4'h4;
    idle(3);
    wb(0, ADDR_STATUS, 0);
    chk("down", ST_QUAL, rv[2:0]);
    chk("dark", 2'b11, {chg_pin, flt_pin});
    env <= 4'hC;
    $display("end suspend");
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence after a 20 cycle reset
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1;
    t_regs;
    t_cycle;
    t_fault;
    t_susp;
    end_sim;
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim;
  end
endmodule
`default_nettype wire
